// ---- tahid_host_model.sv ----
`timescale 1ns/1ps
// host side of the register port, standing in for the serial engine
module tahid_host_model import tahid_pkg::*; (
    input wire logic mclk_i,
    input wire logic [15:0] rdata_i,
    output tahid_req_t req_o
);
    initial req_o = '0;
    // no checksum here: the serial engine owns integrity
    task automatic reg_write(input logic [3:0] a, input logic [15:0] wd);
        @(negedge mclk_i);
        req_o = '{rd: 1'b0, wr: 1'b1, addr: a, wdata: wd};
        @(negedge mclk_i);
        req_o = '{rd: 1'b0, wr: 1'b0, addr: ~a, wdata: ~wd}; // released bus toggles
    endtask
    // data is taken one falling edge after the request edge
    task automatic reg_read(input logic [3:0] a, output logic [15:0] d);
        @(negedge mclk_i);
        req_o = '{rd: 1'b1, wr: 1'b0, addr: a, wdata: 16'h0000};
        @(negedge mclk_i);
        d = rdata_i;
        req_o = '{rd: 1'b0, wr: 1'b0, addr: ~a, wdata: 16'hFFFF};
    endtask
endmodule // tahid_host_model

// ---- tahid_pkg.sv ----
package tahid_pkg;

    // register offsets on the internal register port
    localparam logic [3:0] HYST_ADDR = 4'h6;
    localparam logic [3:0] SLEW_ADDR = 4'h7;
    localparam logic [3:0] UID_HI_ADDR = 4'h8;
    localparam logic [3:0] UID_MID_ADDR = 4'h9;
    localparam logic [3:0] UID_LO_ADDR = 4'hA;
    localparam logic [3:0] PART_ADDR = 4'hB;

    // reset values
    localparam logic [15:0] HYST_RST = 16'h0A0A;
    localparam logic [15:0] SLEW_RST = 16'h0500;

    // field positions
    localparam int UPPER_MARGIN_LSB = 8;
    localparam int SLEW_FIELD_LSB = 2;
    localparam int SLEW_FIELD_MSB = 14;
    localparam logic [15:0] SLEW_WR_MASK = 16'h7FFC;
    // one margin count is 64 counts of the 1/128 degree result scale
    localparam int MARGIN_SHIFT = 6;

    // timing: the period counter runs on a 50 us tick
    localparam int CLK_PERIOD_NS = 40;
    localparam int TICK_NS = 50000;
    localparam int TICK_CYC = TICK_NS / CLK_PERIOD_NS;
    localparam int TICKS_PER_S = 1000000000 / TICK_NS;
    // result LSB is a quarter of a slew LSB per second
    localparam logic [31:0] SLEW_NUM = 32'(TICKS_PER_S / 4);
    localparam logic [2:0] PERIOD_SEL_RST = 3'h4;

    // conversion periods 6.4 ms .. 2 s, in ticks
    localparam logic [15:0] PERIOD_TICKS [8] = '{
        16'h0080, 16'h0271, 16'h04E2, 16'h09C4,
        16'h1388, 16'h2710, 16'h4E20, 16'h9C40
    };

    typedef struct packed {
        logic rd;
        logic wr;
        logic [3:0] addr;
        logic [15:0] wdata;
    } tahid_req_t;

    typedef struct packed {
        logic valid;
        logic [15:0] temp;
    } tahid_conv_t;

    typedef struct packed {
        logic [13:0] upper_temp_threshold;
        logic [13:0] lower_temp_threshold;
    } tahid_lim_t;

endpackage

// ---- tahid_regs.sv ----
`timescale 1ns/1ps

module tahid_regs import tahid_pkg::*; #(
    parameter int TICK_CYCLES = TICK_CYC,
    parameter logic [47:0] SERIAL_ID = 48'h0123_4567_89AB, // arbitrary
    parameter logic [3:0] REV_CODE = 4'h3, // arbitrary
    parameter logic [11:0] PART_IDENTIFIER = 12'h5A5 // arbitrary
) (
    input wire logic mclk_i,
    input wire logic sys_rst_i,
    input wire tahid_req_t req_i,
    input wire tahid_conv_t conv_i,
    input wire tahid_lim_t lim_i,
    input wire logic [2:0] period_sel_i,
    output logic [15:0] rdata_o,
    output logic conv_start_o,
    output logic high_alert_o,
    output logic low_alert_o,
    output logic slew_alert_o
);

    // margin byte to result scale
    function automatic logic signed [17:0] margin_f(input logic [7:0] m);
        return {4'h0, m, 6'h00};
    endfunction

    // 14-bit limit to result scale
    function automatic logic signed [17:0] limit_f(input logic [13:0] l);
        return {{2{l[13]}}, l, 2'b00};
    endfunction

    logic [15:0] hyst_reg;
    logic [15:0] slew_reg;
    logic [15:0] rdata_reg;
    logic [11:0] tick_cnt_reg;
    logic [15:0] prd_cnt_reg;
    logic [15:0] prd_len_reg;
    logic [15:0] meas_ticks_reg;
    logic conv_start_reg;
    logic [15:0] prev_temp_reg;
    logic prev_ok_reg;
    logic high_reg;
    logic low_reg;
    logic slew_alert_reg;

    // register decode
    wire logic hyst_wr_w = req_i.wr && req_i.addr == HYST_ADDR;
    wire logic slew_wr_w = req_i.wr && req_i.addr == SLEW_ADDR;
    wire logic [7:0] upper_alert_margin = hyst_reg[UPPER_MARGIN_LSB +: 8];
    wire logic [7:0] lower_alert_margin = hyst_reg[7:0];
    wire logic [12:0] slew_field_w = slew_reg[SLEW_FIELD_MSB:SLEW_FIELD_LSB];
    wire logic [15:0] part_code_w = {REV_CODE, PART_IDENTIFIER};

    // read mux, unmapped offsets answer zero
    logic [15:0] rd_mux_w;
    always_comb begin
        unique case (req_i.addr)
            HYST_ADDR: rd_mux_w = hyst_reg;
            SLEW_ADDR: rd_mux_w = slew_reg;
            UID_HI_ADDR: rd_mux_w = SERIAL_ID[47:32];
            UID_MID_ADDR: rd_mux_w = SERIAL_ID[31:16];
            UID_LO_ADDR: rd_mux_w = SERIAL_ID[15:0];
            PART_ADDR: rd_mux_w = part_code_w;
            default: rd_mux_w = 16'h0000;
        endcase
    end

    // writable registers; identifier words have no storage to write
    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            hyst_reg <= HYST_RST;
            slew_reg <= SLEW_RST;
        end else begin
            if (hyst_wr_w) begin
                hyst_reg <= req_i.wdata;
            end
            if (slew_wr_w) begin
                slew_reg <= req_i.wdata & SLEW_WR_MASK;
            end
        end
    end

    // read data held until the next read; checksum is added downstream
    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            rdata_reg <= 16'h0000;
        end else if (req_i.rd) begin
            rdata_reg <= rd_mux_w;
        end
    end

    // conversion period timing
    // a slow tick keeps the period counter at 16 bits for the 2 s setting;
    // the price is that periods are whole ticks, which all eight settings are.
    // the counter restarts on its own, so a missed start cannot stall it
    wire logic tick_w = tick_cnt_reg == 12'(TICK_CYCLES - 1);
    wire logic prd_end_w = tick_w && (prd_cnt_reg == prd_len_reg - 16'h0001);
    wire logic [15:0] sel_ticks_w = PERIOD_TICKS[period_sel_i];

    // new period length takes effect at the next period boundary
    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            tick_cnt_reg <= 12'h000;
            prd_cnt_reg <= 16'h0000;
            prd_len_reg <= PERIOD_TICKS[PERIOD_SEL_RST];
            meas_ticks_reg <= PERIOD_TICKS[PERIOD_SEL_RST];
            conv_start_reg <= 1'b0;
        end else begin
            tick_cnt_reg <= tick_w ? 12'h000 : tick_cnt_reg + 12'h001;
            conv_start_reg <= prd_end_w;
            if (prd_end_w) begin
                prd_cnt_reg <= 16'h0000;
                prd_len_reg <= sel_ticks_w;
                meas_ticks_reg <= prd_len_reg;
            end else if (tick_w) begin
                prd_cnt_reg <= prd_cnt_reg + 16'h0001;
            end
        end
    end

    // thresholds on the result scale
    // limits and margins are widened to 18 bits so the release levels
    // near the ends of the range neither wrap nor saturate
    wire logic signed [17:0] temp_w = {{2{conv_i.temp[15]}}, conv_i.temp};
    wire logic signed [17:0] prev_w = {{2{prev_temp_reg[15]}}, prev_temp_reg};
    wire logic signed [17:0] hi_w = limit_f(lim_i.upper_temp_threshold);
    wire logic signed [17:0] lo_w = limit_f(lim_i.lower_temp_threshold);
    wire logic signed [17:0] hi_rel_w = hi_w - margin_f(upper_alert_margin);
    wire logic signed [17:0] lo_rel_w = lo_w + margin_f(lower_alert_margin);
    wire logic lim_ok_w = hi_w > lo_w;

    // hysteresis state of each limit alert
    // a result equal to a limit or a release level leaves the alert alone;
    // invalid limits win over any result in the same cycle
    wire logic high_next = (temp_w > hi_w) || (high_reg && !(temp_w < hi_rel_w));
    wire logic low_next = (temp_w < lo_w) || (low_reg && !(temp_w > lo_rel_w));

    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            high_reg <= 1'b0;
            low_reg <= 1'b0;
        end else if (!lim_ok_w) begin
            high_reg <= 1'b0;
            low_reg <= 1'b0;
        end else if (conv_i.valid) begin
            high_reg <= high_next;
            low_reg <= low_next;
        end
    end

    // slew check without a divider: delta*ticks_per_s/4 > limit*ticks
    // both products stay below 2^32 for the largest delta and limit,
    // so the compare is exact; a falling or flat delta never alerts.
    // the period used is the one that ended at the last start, which is
    // the interval the two results really span
    wire logic signed [17:0] delta_w = temp_w - prev_w;
    wire logic rising_w = delta_w > 18'sd0;
    wire logic [31:0] rise_scaled_w = 32'(delta_w[16:0]) * SLEW_NUM;
    wire logic [31:0] limit_scaled_w = 32'(slew_field_w) * 32'(meas_ticks_reg);
    wire logic slew_next = prev_ok_reg && rising_w && (rise_scaled_w > limit_scaled_w);

    // first result after reset has no predecessor and cannot alert
    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            prev_temp_reg <= 16'h0000;
            prev_ok_reg <= 1'b0;
            slew_alert_reg <= 1'b0;
        end else if (conv_i.valid) begin
            prev_temp_reg <= conv_i.temp;
            prev_ok_reg <= 1'b1;
            slew_alert_reg <= slew_next;
        end
    end

    assign rdata_o = rdata_reg;
    assign conv_start_o = conv_start_reg;
    assign high_alert_o = high_reg;
    assign low_alert_o = low_reg;
    assign slew_alert_o = slew_alert_reg;

    // checks
    // all checks run on the one clock and sleep while reset is high;
    // the reset checks look at the first edge after release instead.
    // read checks expect the old value when a write hits the same edge
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (sys_rst_i);

    hyst_reset_a: assert property ($fell(sys_rst_i) |-> hyst_reg == HYST_RST)
        else $error("margin register not at reset value");
    slew_reset_a: assert property ($fell(sys_rst_i) |-> slew_reg == SLEW_RST)
        else $error("slew register not at reset value");
    slew_rsvd_a: assert property (slew_reg[15] == 1'b0 && slew_reg[1:0] == 2'b00)
        else $error("slew reserved bits not zero");
    hyst_write_a: assert property (hyst_wr_w |=> hyst_reg == $past(req_i.wdata))
        else $error("margin write lost");
    part_read_a: assert property (req_i.rd && req_i.addr == PART_ADDR
        |=> rdata_o == {REV_CODE, PART_IDENTIFIER})
        else $error("part code read wrong");
    uid_read_a: assert property (req_i.rd && req_i.addr == UID_MID_ADDR
        |=> rdata_o == SERIAL_ID[31:16])
        else $error("serial identifier read wrong");
    high_set_a: assert property (conv_i.valid && lim_ok_w && temp_w > hi_w
        |=> high_alert_o)
        else $error("high alert not set");
    high_hold_a: assert property (conv_i.valid && lim_ok_w && high_reg
        && temp_w >= hi_rel_w |=> high_alert_o)
        else $error("high alert released early");
    low_release_a: assert property (conv_i.valid && lim_ok_w && temp_w > lo_rel_w
        && temp_w >= lo_w |=> !low_alert_o)
        else $error("low alert not released");
    limit_ignore_a: assert property (!lim_ok_w |=> !high_alert_o && !low_alert_o)
        else $error("alert with limits ignored");
    slew_fall_a: assert property (conv_i.valid && !rising_w |=> !slew_alert_o)
        else $error("slew alert on falling slope");
    conv_gap_a: assert property (conv_start_o |=> !conv_start_o [*4])
        else $error("conversion starts too close");


    // outputs come out of reset quiet
    out_reset_a: assert property ($fell(sys_rst_i) |-> rdata_o == 16'h0000
        && !high_alert_o && !low_alert_o && !slew_alert_o && !conv_start_o)
        else $error("outputs not quiet after reset");

    prd_reset_a: assert property ($fell(sys_rst_i)
        |-> prd_len_reg == PERIOD_TICKS[PERIOD_SEL_RST])
        else $error("period length not at reset value");

    // register port: reads return the value before any same-cycle write
    hyst_read_a: assert property (req_i.rd && req_i.addr == HYST_ADDR
        |=> rdata_o == $past(hyst_reg))
        else $error("margin read wrong");

    slew_read_a: assert property (req_i.rd && req_i.addr == SLEW_ADDR
        |=> rdata_o == $past(slew_reg))
        else $error("slew read wrong");

    uid_hi_read_a: assert property (req_i.rd && req_i.addr == UID_HI_ADDR
        |=> rdata_o == SERIAL_ID[47:32])
        else $error("upper serial word read wrong");

    uid_lo_read_a: assert property (req_i.rd && req_i.addr == UID_LO_ADDR
        |=> rdata_o == SERIAL_ID[15:0])
        else $error("lower serial word read wrong");

    // unmapped offsets must not leak a neighbour's value
    unmapped_read_a: assert property (req_i.rd
        && (req_i.addr < HYST_ADDR || req_i.addr > PART_ADDR) |=> rdata_o == 16'h0000)
        else $error("unmapped read not zero");

    // the serial engine may resend a word, so it must not move between reads
    rdata_hold_a: assert property (!req_i.rd |=> $stable(rdata_o))
        else $error("read data moved without a read");

    // slew writes land masked, and nothing else touches the writable registers
    slew_write_a: assert property (slew_wr_w
        |=> slew_reg == ($past(req_i.wdata) & SLEW_WR_MASK))
        else $error("slew write lost");

    hyst_keep_a: assert property (!hyst_wr_w |=> $stable(hyst_reg))
        else $error("margin register changed without a write");

    slew_keep_a: assert property (!slew_wr_w |=> $stable(slew_reg))
        else $error("slew register changed without a write");

    // low set and hold mirror the high side checks above; high release mirrors the low release check
    low_set_a: assert property (conv_i.valid && lim_ok_w && temp_w < lo_w
        |=> low_alert_o)
        else $error("low alert not set");

    low_hold_a: assert property (conv_i.valid && lim_ok_w && low_reg
        && temp_w <= lo_rel_w |=> low_alert_o)
        else $error("low alert released early");

    high_release_a: assert property (conv_i.valid && lim_ok_w && temp_w < hi_rel_w
        |=> !high_alert_o)
        else $error("high alert not released");

    // alerts only move on a result, or when the limits turn invalid
    alert_idle_a: assert property (!conv_i.valid && lim_ok_w
        |=> $stable(high_alert_o) && $stable(low_alert_o))
        else $error("limit alert moved without a result");

    // no predecessor after reset, so no slope to judge
    slew_first_a: assert property (conv_i.valid && !prev_ok_reg |=> !slew_alert_o)
        else $error("slew alert on first result");

    slew_idle_a: assert property (!conv_i.valid |=> $stable(slew_alert_o))
        else $error("slew alert moved without a result");

    // helper for the period check: cycles since the last start, or since reset
    logic [31:0] gap_cnt_reg;
    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            gap_cnt_reg <= 32'h00000000;
        end else begin
            gap_cnt_reg <= conv_start_o ? 32'h00000001 : gap_cnt_reg + 32'h00000001;
        end
    end

    // each start ends a period whose length was fixed at the previous start
    period_len_a: assert property (conv_start_o
        |-> gap_cnt_reg == 32'(meas_ticks_reg) * 32'(TICK_CYCLES))
        else $error("conversion period length wrong");

    // a new select must wait for the boundary
    prd_len_keep_a: assert property (!prd_end_w
        |=> $stable(prd_len_reg) && $stable(meas_ticks_reg))
        else $error("period length changed inside a period");

    tick_range_a: assert property (tick_cnt_reg < 12'(TICK_CYCLES))
        else $error("tick counter out of range");

    prd_range_a: assert property (prd_cnt_reg < prd_len_reg)
        else $error("period counter out of range");

    high_cycle_c: cover property (high_alert_o ##[1:1000] !high_alert_o);
    low_cycle_c: cover property (low_alert_o ##[1:1000] !low_alert_o);
    slew_alert_c: cover property ($rose(slew_alert_o));
    conv_start_c: cover property (conv_start_o);
    slew_write_c: cover property (slew_wr_w);

endmodule // tahid_regs

// ---- tb_top.sv ----
`timescale 1ns/1ps
module tb_top import tahid_pkg::*;;
    localparam logic [47:0] SID = 48'hA5C3_1E2D_7B90; // arbitrary
    localparam logic [3:0] REV = 4'h2; // arbitrary
    localparam logic [11:0] PID = 12'h3C7; // arbitrary
    logic mclk_i, sys_rst_i, conv_start_o, high_alert_o, low_alert_o, slew_alert_o;
    tahid_req_t req;
    tahid_conv_t conv_i;
    tahid_lim_t lim_i;
    logic [2:0] period_sel_i;
    logic [15:0] rdata_o, d, w;
    int err_count, checks, n;
    int cyc = 0;
    // cycles since reset release, for the first period
    always @(posedge mclk_i) if (!sys_rst_i) cyc <= cyc + 1;
    tahid_regs #(.TICK_CYCLES(2), .SERIAL_ID(SID), .REV_CODE(REV), .PART_IDENTIFIER(PID))
    tahid_regs_inst (.mclk_i(mclk_i), .sys_rst_i(sys_rst_i), .req_i(req), .conv_i(conv_i),
        .lim_i(lim_i), .period_sel_i(period_sel_i), .rdata_o(rdata_o),
        .conv_start_o(conv_start_o), .high_alert_o(high_alert_o), .low_alert_o(low_alert_o),
        .slew_alert_o(slew_alert_o));
    tahid_host_model tahid_host_model_inst (.mclk_i(mclk_i), .rdata_i(rdata_o), .req_o(req));
    initial begin
        mclk_i = 1'b0;
        forever #20 mclk_i = ~mclk_i;
    end
    task automatic chk16(string s, logic [15:0] e, logic [15:0] g);
        checks++;
        if (g !== e) begin
            err_count++;
            $display("CHECK FAILED %s expected %h seen %h", s, e, g);
        end
    endtask
    task automatic chk1(string s, logic e, logic g);
        chk16(s, {15'h0000, e}, {15'h0000, g});
    endtask
    task automatic rd_chk(logic [3:0] a, logic [15:0] e);
        tahid_host_model_inst.reg_read(a, d);
        chk16("rdata", e, d);
    endtask
    // result pulse, then one spare cycle so the alert levels have settled
    task automatic temp(logic [15:0] t);
        @(negedge mclk_i);
        conv_i = '{valid: 1'b1, temp: t};
        @(negedge mclk_i);
        conv_i.valid = 1'b0;
        @(negedge mclk_i);
    endtask
    // release level: limit minus margin going down, plus margin going up
    function automatic logic [15:0] rel(logic [13:0] l, logic [7:0] m, bit up);
        return up ? {l, 2'b00} - {2'b00, m, 6'h00} : {l, 2'b00} + {2'b00, m, 6'h00};
    endfunction
    // rising delta against reset slew field over a 128-tick period
    function automatic logic slew_exp(int dt);
        return dt * 5000 > 320 * 128;
    endfunction
    task automatic test_done();
        $display("checks %0d mismatches %0d", checks, err_count);
        if (err_count == 0 && checks > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    // bounded wait for the next conversion start, n counts the cycles
    task automatic wait_start(int lim);
        for (n = 1; n < lim && conv_start_o !== 1'b1; n++) @(negedge mclk_i);
        if (n >= lim) begin
            err_count++;
            test_done();
        end
        @(negedge mclk_i);
    endtask
    initial begin
        sys_rst_i = 1'b1;
        conv_i = '0;
        lim_i = '{upper_temp_threshold: 14'h0C80, lower_temp_threshold: 14'h0000};
        period_sel_i = 3'h0;
        err_count = 0;
        checks = 0;
        void'($urandom(32'h638f313e));
        repeat (8) @(negedge mclk_i);
        sys_rst_i = 1'b0;
        rd_chk(4'h6, 16'h0A0A);
        rd_chk(4'h7, 16'h0500);
        rd_chk(4'h8, SID[47:32]);
        rd_chk(4'h9, SID[31:16]);
        rd_chk(4'hA, SID[15:0]);
        rd_chk(4'hB, {REV, PID});
        tahid_host_model_inst.reg_write(4'hB, 16'hFFFF);
        rd_chk(4'hB, {REV, PID});
        rd_chk(4'hC, 16'h0000);
        $display("test reset and identity done");
        // random writes, with the all-ones slew corner last
        for (int i = 0; i < 9; i++) begin
            w = (i == 8) ? 16'hFFFF : 16'($urandom());
            tahid_host_model_inst.reg_write(4'h6, w);
            tahid_host_model_inst.reg_write(4'h7, w);
            rd_chk(4'h6, w);
            rd_chk(4'h7, w & 16'h7FFC);
        end
        tahid_host_model_inst.reg_write(4'h7, 16'h0500);
        tahid_host_model_inst.reg_write(4'h6, 16'h0A05);
        $display("test register access done");
        // margins differ so a byte swap shows up
        temp(rel(14'h0C80, 8'h00, 1'b1));
        chk1("high", 1'b0, high_alert_o);
        temp(rel(14'h0C80, 8'h00, 1'b1) + 16'h0001);
        chk1("high", 1'b1, high_alert_o);
        temp(rel(14'h0C80, 8'h0A, 1'b1));
        chk1("high", 1'b1, high_alert_o);
        temp(rel(14'h0C80, 8'h0A, 1'b1) - 16'h0001);
        chk1("high", 1'b0, high_alert_o);
        temp(16'hFFFF);
        chk1("low", 1'b1, low_alert_o);
        temp(rel(14'h0000, 8'h05, 1'b0));
        chk1("low", 1'b1, low_alert_o);
        temp(rel(14'h0000, 8'h05, 1'b0) + 16'h0001);
        chk1("low", 1'b0, low_alert_o);
        temp(16'h7000);
        lim_i.lower_temp_threshold = 14'h0C80;
        repeat (2) @(negedge mclk_i);
        chk1("high", 1'b0, high_alert_o);
        lim_i.lower_temp_threshold = 14'h0000;
        $display("test alerts done");
        wait_start(12000);
        chk16("first period", 16'(PERIOD_TICKS[PERIOD_SEL_RST] * 2 + 1), 16'(cyc));
        wait_start(600);
        chk16("period", 16'd256, 16'(n));
        temp(16'h0000);
        temp(16'h0008);
        chk1("slew", slew_exp(8), slew_alert_o);
        temp(16'h0011);
        chk1("slew", slew_exp(9), slew_alert_o);
        temp(16'h000A);
        chk1("slew", 1'b0, slew_alert_o);
        $display("test timer and slew done");
        test_done();
    end
endmodule // tb_top
